/* rtl/crv_pkg.sv */
// shared constants and types for the readback verifier ends
package crv_pkg;
  // frame geometry (bits)
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned PAD_FRAMES = 1;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  // host clock divider: last divider count of a link clock half period (half period is DIV_HALF+1 = 4 mclk cycles)
  localparam logic [1:0]  DIV_HALF   = 2'h3;
  // compare schemes
  typedef enum logic {
    CRV_GOLDEN,
    CRV_BITSTREAM
  } crv_scheme_t;
  // reference word: expected bit and mask bit
  typedef struct packed {
    logic       exp_bit;
    logic       msk_bit;
  } crv_ref_t;
endpackage

/* rtl/crv_link_if.sv */
// serial readback link between device and host
`timescale 1ns/10ps
`default_nettype none
interface crv_link_if;
  logic tck;
  logic rd_ctl;
  logic start;
  logic rbk_bit;
  logic rbk_vld;
  logic crc_clr;
  modport dev (
    input  tck,
    input  rd_ctl,
    input  start,
    input  crc_clr,
    output rbk_bit,
    output rbk_vld
  );
  modport host (
    output tck,
    output rd_ctl,
    output start,
    output crc_clr,
    input  rbk_bit,
    input  rbk_vld
  );
endinterface
`default_nettype wire

/* rtl/crv_dev.sv */
// device end: streams pad frame then configuration frames on the link clock
`timescale 1ns/10ps
`default_nettype none
module crv_dev (
  // link
  crv_link_if.dev             lnk,
  // configuration memory view
  output logic [15:0]         mem_addr,
  input  wire logic           mem_bit,
  input  wire logic [15:0]    mem_len,
  // status
  output logic                crc_err,
  // reset in link domain
  input  wire logic           rst_b
);
  typedef enum logic [1:0] {IDLE, PAD, DATA} crv_dst_t;
  typedef struct packed {
    crv_dst_t    st;
    logic [15:0] cnt;
    logic        bit_o;
    logic        vld_o;
    logic        crc_e;
  } crv_dev_st_t;
  crv_dev_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.vld_o = 1'b0;
    s_d.bit_o = 1'b0;
    if (lnk.crc_clr) begin
      s_d.crc_e = 1'b0;
    end
    case (s_q.st)
      IDLE: begin
        // insitu_read_register path: no command words received
        if (lnk.start && lnk.rd_ctl) begin
          s_d.st  = PAD;
          s_d.cnt = crv_pkg::CNT_RESET;
          s_d.crc_e = 1'b1;
        end
      end
      PAD: begin
        // one pad frame ahead of frame data
        s_d.vld_o = 1'b1;
        s_d.cnt = s_q.cnt + crv_pkg::CNT_ONE;
        if (s_q.cnt == 16'(crv_pkg::FRAME_BITS * crv_pkg::PAD_FRAMES - 1)) begin
          s_d.st  = DATA;
          s_d.cnt = crv_pkg::CNT_RESET;
        end
      end
      DATA: begin
        // raw frame bits only, no headers, no crc
        s_d.vld_o = 1'b1;
        s_d.bit_o = mem_bit;
        s_d.cnt = s_q.cnt + crv_pkg::CNT_ONE;
        if (s_q.cnt == mem_len - crv_pkg::CNT_ONE || !lnk.rd_ctl) begin
          s_d.st = IDLE;
        end
      end
      default: s_d.st = IDLE;
    endcase
  end

  always_ff @(posedge lnk.tck) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.rbk_bit = s_q.bit_o;
  assign lnk.rbk_vld = s_q.vld_o;
  assign mem_addr    = s_q.cnt;
  assign crc_err     = s_q.crc_e;
endmodule
`default_nettype wire

/* rtl/crv_host.sv */
// host end: drives readback, buffers bits, compares under mask
// Operation
// - device reads memory via in-situ read register
// - host clears crc error after readback
// - compare when mask 0, skip when 1
// - device sends one pad frame first
// - stream holds frame data, no commands
// - no crc computed over readback data
// - golden compare aligns pad-inclusive first bits
// - bitstream compare aligns to write payload
// - bitstream compare stops at payload end
// - host switches port to read control
// - text reference bits packed one per bit
`timescale 1ns/10ps
`default_nettype none
module crv_host (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_b,
  // link
  crv_link_if.host                 lnk,
  // control
  input  wire logic                go,
  input  wire crv_pkg::crv_scheme_t scheme,
  input  wire logic [15:0]         cmp_len,
  // reference stream (expected and mask, packed binary)
  input  wire logic                ref_valid,
  input  wire crv_pkg::crv_ref_t   ref_data,
  output logic                     ref_ready,
  // results
  output logic                     mismatch,
  output logic                     done,
  output logic                     busy
);
  // ----------------------------------------------------------------
  // link domain: sample device bit, pass by toggle + data
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tgl;
    logic dat;
  } crv_lk_st_t;
  crv_lk_st_t l_q, l_d;

  always_comb begin
    l_d = l_q;
    if (lnk.rbk_vld) begin
      l_d.tgl = ~l_q.tgl;
      l_d.dat = lnk.rbk_bit;
    end
  end

  // tck is still during reset: clear again while read control is off
  always_ff @(posedge lnk.tck) begin
    if (!rst_b || !lnk.rd_ctl) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // ----------------------------------------------------------------
  // main domain state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {H_IDLE, H_SKIP, H_RUN, H_CLR, H_END} crv_hst_t;
  typedef struct packed {
    crv_hst_t    st;
    logic [1:0]  div;
    logic        tck;
    logic        rd;
    logic        strt;
    logic        clr;
    logic [2:0]  t_sync;
    logic [1:0]  d_sync;
    logic [15:0] cnt;
    logic [1:0]  bf_v;
    logic [1:0]  bf_d;
    logic        rd_ptr;
    logic        wr_ptr;
    logic        miss;
    logic        dn;
    logic        ack;
    logic        seen;
    logic        bsy;
  } crv_h_st_t;
  crv_h_st_t h_q, h_d;

  logic bit_evt;
  logic bit_val;
  logic bf_full;
  logic bf_empty;
  logic bf_head;
  logic take;

  always_comb begin
    bit_evt  = h_q.t_sync[2] ^ h_q.t_sync[1];
    bit_val  = h_q.d_sync[1];
    bf_full  = &h_q.bf_v;
    bf_empty = ~|h_q.bf_v;
    bf_head  = h_q.bf_d[h_q.rd_ptr];
    take     = !bf_empty && ref_valid && !h_q.ack
               && (h_q.st == H_RUN);
  end

  always_comb begin
    h_d = h_q;
    h_d.ack = 1'b0;
    h_d.dn  = 1'b0;
    // link clock made from mclk by divider
    h_d.div = h_q.div + 2'h1;
    if (h_q.div == crv_pkg::DIV_HALF) begin
      h_d.div = 2'h0;
      h_d.tck = ~h_q.tck;
    end
    h_d.t_sync = {h_q.t_sync[1:0], l_q.tgl};
    h_d.d_sync = {h_q.d_sync[0], l_q.dat};
    // request seen in a low phase is held through the next rising edge
    if ((h_q.strt || h_q.clr) && !h_q.tck
        && h_q.div != crv_pkg::DIV_HALF) begin
      h_d.seen = 1'b1;
    end
    if (h_q.strt && h_q.seen && h_q.tck
        && h_q.div == crv_pkg::DIV_HALF) begin
      h_d.strt = 1'b0;
      h_d.seen = 1'b0;
    end
    // two-entry buffer, write side from link
    if (bit_evt && !bf_full && h_q.st != H_IDLE) begin
      h_d.bf_v[h_q.wr_ptr] = 1'b1;
      h_d.bf_d[h_q.wr_ptr] = bit_val;
      h_d.wr_ptr = ~h_q.wr_ptr;
    end
    if (take) begin
      h_d.bf_v[h_q.rd_ptr] = 1'b0;
      h_d.rd_ptr = ~h_q.rd_ptr;
      h_d.ack = 1'b1;
      h_d.cnt = h_q.cnt + crv_pkg::CNT_ONE;
      // compare only unmasked bits, flag sticky
      if (!ref_data.msk_bit && (bf_head != ref_data.exp_bit)) begin
        h_d.miss = 1'b1;
      end
      // stop at end of range
      if (h_q.cnt == cmp_len - crv_pkg::CNT_ONE) begin
        h_d.st   = H_CLR;
        h_d.rd   = 1'b0;
        h_d.seen = 1'b0;
      end
    end
    case (h_q.st)
      H_IDLE: begin
        if (go) begin
          // switch to read control before shifting
          h_d.rd     = 1'b1;
          h_d.strt   = 1'b1;
          h_d.miss   = 1'b0;
          h_d.cnt    = crv_pkg::CNT_RESET;
          h_d.bf_v   = 2'h0;
          h_d.rd_ptr = 1'b0;
          h_d.wr_ptr = 1'b0;
          h_d.seen   = 1'b0;
          // golden keeps pad frame, bitstream skips it
          h_d.st = (scheme == crv_pkg::CRV_GOLDEN) ? H_RUN : H_SKIP;
        end
      end
      H_SKIP: begin
        // drop pad frame so first data bit meets payload start
        if (!bf_empty) begin
          h_d.bf_v[h_q.rd_ptr] = 1'b0;
          h_d.rd_ptr = ~h_q.rd_ptr;
          h_d.cnt = h_q.cnt + crv_pkg::CNT_ONE;
          if (h_q.cnt == 16'(crv_pkg::FRAME_BITS - 1)) begin
            h_d.cnt = crv_pkg::CNT_RESET;
            h_d.st  = H_RUN;
          end
        end
      end
      H_RUN: begin
      end
      H_CLR: begin
        // clear crc error status, held over a link edge
        h_d.clr = 1'b1;
        if (h_q.seen && h_q.tck && h_q.div == crv_pkg::DIV_HALF) begin
          h_d.st   = H_END;
          h_d.seen = 1'b0;
        end
      end
      H_END: begin
        h_d.clr = 1'b0;
        h_d.dn  = 1'b1;
        h_d.st  = H_IDLE;
      end
      default: h_d.st = H_IDLE;
    endcase
    h_d.bsy = (h_d.st != H_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      h_q <= '0;
      h_q.st <= H_IDLE;
    end else begin
      h_q <= h_d;
    end
  end

  assign lnk.tck     = h_q.tck;
  assign lnk.rd_ctl  = h_q.rd;
  assign lnk.start   = h_q.strt;
  assign lnk.crc_clr = h_q.clr;
  assign ref_ready   = h_q.ack;
  assign mismatch    = h_q.miss;
  assign done        = h_q.dn;
  assign busy        = h_q.bsy;
endmodule
`default_nettype wire

/* test/crv_assertions.sv */
// link checks for the readback verifier
`timescale 1ns/10ps
`default_nettype none
module crv_assertions (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link
  input wire logic tck,
  input wire logic rd_ctl,
  input wire logic start,
  input wire logic rbk_bit,
  input wire logic rbk_vld,
  input wire logic crc_clr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_tck_half; $rose(tck) |-> tck[*4] ##1 !tck; endproperty
  a_tck_half: assert property (p_tck_half)
    else $error("link clock phase length");
  property p_start_rd; start |-> rd_ctl; endproperty
  a_start_rd: assert property (p_start_rd)
    else $error("start without read control");
  property p_start_len; $rose(start) |-> ##[1:16] !start; endproperty
  a_start_len: assert property (p_start_len)
    else $error("start held too long");
  property p_vld_rd; $rose(rbk_vld) |-> rd_ctl; endproperty
  a_vld_rd: assert property (p_vld_rd)
    else $error("bit sent without read control");
  property p_vld_first;
    start && rd_ctl && $rose(tck) |-> ##[1:20] rbk_vld;
  endproperty
  a_vld_first: assert property (p_vld_first)
    else $error("stream late after start");
  property p_vld_width; $rose(rbk_vld) |-> rbk_vld[*8]; endproperty
  a_vld_width: assert property (p_vld_width)
    else $error("bit marker shorter than a link period");
  property p_bit_hold;
    rbk_vld && $changed(rbk_bit) |-> tck && !$past(tck);
  endproperty
  a_bit_hold: assert property (p_bit_hold)
    else $error("bit changed off the link edge");
  property p_clr_len; $rose(crc_clr) |-> ##[1:20] !crc_clr; endproperty
  a_clr_len: assert property (p_clr_len)
    else $error("status clear stuck");
  c_clr: cover property ($rose(crc_clr));
  c_vld: cover property ($rose(rbk_vld));
  c_start: cover property ($fell(start));
endmodule
`default_nettype wire

/* test/test_config_readback_verifier.sv */
// bench for the readback verifier, both ends on one link
`timescale 1ns/10ps
`default_nettype none
module test_config_readback_verifier;
  logic                 mclk, rst_b, go, ref_valid, mem_bit, lnk_rst_b;
  logic                 ref_ready, mismatch, done, busy, crc_err;
  logic [15:0]          mem_addr, mem_len, cmp_len;
  crv_pkg::crv_scheme_t scheme;
  crv_pkg::crv_ref_t    ref_data;
  int                   bad_count, checked, n_vld;
  crv_link_if lnk ();
  crv_dev crv_dev_i (.lnk(lnk.dev), .mem_addr, .mem_bit, .mem_len,
    .crc_err, .rst_b(lnk_rst_b));
  crv_host crv_host_i (.mclk, .rst_b, .lnk(lnk.host), .go, .scheme,
    .cmp_len, .ref_valid, .ref_data, .ref_ready, .mismatch, .done,
    .busy);
  crv_assertions crv_assertions_i (.mclk, .rst_b, .tck(lnk.tck),
    .rd_ctl(lnk.rd_ctl), .start(lnk.start), .rbk_bit(lnk.rbk_bit),
    .rbk_vld(lnk.rbk_vld), .crc_clr(lnk.crc_clr));
  // memory content pattern
  function automatic logic pat(input int k);
    return k[0] ^ k[2];
  endfunction
  assign mem_bit = pat(int'(mem_addr));
  task automatic chk(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t: saw %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one readback and compare pass
  task automatic run(input crv_pkg::crv_scheme_t s, input int len,
                     input int flip, input logic fmsk, input logic want);
    int i, k, t;
    n_vld = 0;
    scheme <= s;
    cmp_len <= len[15:0];
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (i = 0; i < len; i++) begin
      k = (s == crv_pkg::CRV_GOLDEN) ? i - 32 : i;
      ref_valid <= 1'b1;
      ref_data.exp_bit <= (k >= 0 && pat(k)) ^ (i == flip);
      ref_data.msk_bit <= (k < 0) | (i == flip && fmsk);
      t = 0;
      do begin
        @(posedge mclk);
        t++;
      end while (ref_ready !== 1'b1 && t < 600);
      if (t >= 600) begin
        bad_count++;
        test_done;
      end
      if (i == 0) chk(crc_err, 1'b1);
    end
    ref_valid <= 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 2000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 2000) begin
      bad_count++;
      test_done;
    end
    chk(busy, 1'b0);
    repeat (16) @(posedge mclk);
    chk(mismatch, want);
    chk(crc_err, 1'b0);
    if (s == crv_pkg::CRV_GOLDEN) chk(n_vld == 48, 1'b1);
  endtask
  // capture mid link period
  always @(negedge lnk.tck) begin
    if (lnk.rbk_vld === 1'b1) begin
      if (n_vld >= 32) chk(lnk.rbk_bit, pat(n_vld - 32));
      n_vld++;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    {rst_b, lnk_rst_b, go, ref_valid, bad_count, checked} = '0;
    mem_len = 16'h0010;
    cmp_len = 16'h0000;
    scheme = crv_pkg::CRV_GOLDEN;
    ref_data = '0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (40) @(posedge mclk);
    lnk_rst_b <= 1'b1;
    repeat (16) @(posedge mclk);
    run(crv_pkg::CRV_GOLDEN, 48, 40, 1'b1, 1'b0);
    run(crv_pkg::CRV_GOLDEN, 48, 40, 1'b0, 1'b1);
    run(crv_pkg::CRV_BITSTREAM, 16, 0, 1'b0, 1'b1);
    run(crv_pkg::CRV_BITSTREAM, 12, -1, 1'b0, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
